// file: core/pfcs_params.svh
// Operation
// RQ1: Enter ID mode: AA@555, 55@AAA, 90@555.
// RQ2: Single F0 write leaves ID mode.
// RQ3: Three-cycle F0 sequence also leaves ID mode.
// RQ4: ID read: A0 low maker, high part.
// RQ5: Power cycle returns device to array read.
// RQ6: After ID exit, reads return array data.
// RQ7: Commands use low byte, low address bits.
// RQ8: Final erase code: 10 chip, 30 main.
// RQ9: OE held high during erase writes.
// RQ10: OE/CE toggles advance toggle bit while busy.
// RQ11: Toggle bit on line 6, polarity undefined.
// RQ12: Poll address fixed across status reads.
// RQ13: Boot sector 0000-1FFF refuses when locked.
// RQ14: Address 2AA may replace AAA.
// RQ15: Busy device answers reads with status.
`ifndef PFCS_PARAMS_SVH
`define PFCS_PARAMS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define PFCS_CLK_NS 50
`define PFCS_T_WP_NS 35
`define PFCS_T_AH_NS 35
`define PFCS_T_ACC_NS 45
`define PFCS_T_OEHP_NS 150
`define PFCS_T_EC_MAX_S 3
`define PFCS_CEIL_CYC(ns) (((ns) + `PFCS_CLK_NS - 1) / `PFCS_CLK_NS)
`define PFCS_WP_CYC `PFCS_CEIL_CYC(`PFCS_T_WP_NS)
`define PFCS_HOLD_CYC `PFCS_CEIL_CYC(`PFCS_T_AH_NS)
`define PFCS_ACC_CYC `PFCS_CEIL_CYC(`PFCS_T_ACC_NS)
`define PFCS_OEHP_CYC `PFCS_CEIL_CYC(`PFCS_T_OEHP_NS)
`define PFCS_EC_MAX_CYC (`PFCS_T_EC_MAX_S * (1000000000 / `PFCS_CLK_NS))
`define PFCS_SYNC_STAGES 2

// ****************************************************************
// Command addresses and codes
// ****************************************************************
`define PFCS_ADDR_UNLOCK1 12'h555
`define PFCS_ADDR_UNLOCK2 12'hAAA
`define PFCS_ADDR_UNLOCK2_ALT 12'h2AA
`define PFCS_DATA_UNLOCK1 8'hAA
`define PFCS_DATA_UNLOCK2 8'h55
`define PFCS_CODE_ID_ENTER 8'h90
`define PFCS_CODE_ID_EXIT 8'hF0
`define PFCS_CODE_ERASE_SETUP 8'h80
`define PFCS_CODE_CHIP_ERASE 8'h10
`define PFCS_CODE_MAIN_ERASE 8'h30
`define PFCS_TOGGLE_BIT 6
`define PFCS_BOOT_LAST 16'h1FFF
`define PFCS_STEP_W 3

`endif

// file: core/pfcs_pkg.sv
package pfcs_pkg;

  typedef enum logic [2:0] {
    PFCS_OP_READ = 3'h0,
    PFCS_OP_WRITE = 3'h1,
    PFCS_OP_ID_ENTER = 3'h2,
    PFCS_OP_ID_EXIT1 = 3'h3,
    PFCS_OP_ID_EXIT3 = 3'h4,
    PFCS_OP_CHIP_ERASE = 3'h5,
    PFCS_OP_MAIN_ERASE = 3'h6,
    PFCS_OP_POLL = 3'h7
  } pfcs_op_t;

  typedef enum logic [2:0] {
    PFCS_CY_IDLE = 3'h0,
    PFCS_CY_SETUP = 3'h1,
    PFCS_CY_STROBE = 3'h3,
    PFCS_CY_HOLD = 3'h2,
    PFCS_CY_RWAIT = 3'h6
  } pfcs_cyc_state_t;

  typedef enum logic [2:0] {
    PFCS_M_IDLE = 3'h0,
    PFCS_M_SEQ = 3'h1,
    PFCS_M_POLL = 3'h3,
    PFCS_M_GAP = 3'h2,
    PFCS_M_READ = 3'h6
  } pfcs_main_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } pfcs_step_t;

endpackage

// file: core/pfcs_cyc_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pfcs_cyc_if;
  logic req;
  logic is_write;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic ack;
  logic [15:0] rdata;

  modport master (output req, output is_write, output addr, output wdata,
                  input ack, input rdata);
  modport engine (input req, input is_write, input addr, input wdata,
                  output ack, output rdata);
endinterface
`default_nettype wire

// file: core/pfcs_cycle.sv
`timescale 1ns/10ps
`default_nettype none
`include "pfcs_params.svh"
module pfcs_cycle (
  input wire logic core_clk_i,           // System clock
  input wire logic reset_n_i,            // Async reset, active low
  pfcs_cyc_if.engine cyc,                // Cycle requests
  output logic [15:0] address_lines_o,   // Flash address pins
  output logic [15:0] data_lines_o,      // Flash data out
  output logic data_lines_oe_o,          // Data drive enable, high drives
  input wire logic [15:0] data_lines_i,  // Flash data in
  output logic ce_n_o,                   // Chip enable, active low
  output logic oe_n_o,                   // Output enable, active low
  output logic we_n_o                    // Write enable, active low
);
  import pfcs_pkg::*;

  localparam logic [3:0] WP_CYC = 4'(`PFCS_WP_CYC);
  localparam logic [3:0] HOLD_CYC = 4'(`PFCS_HOLD_CYC);
  // Access time plus the synchroniser depth before data is trusted
  localparam logic [3:0] RD_CYC = 4'(`PFCS_ACC_CYC + `PFCS_SYNC_STAGES);

  pfcs_cyc_state_t state_r;
  logic [3:0] cnt_r;
  logic [15:0] sync1_r;
  logic [15:0] sync2_r;

  // ****************************************************************
  // Data input synchroniser
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_r <= 16'h0000;
      sync2_r <= 16'h0000;
    end else begin
      sync1_r <= data_lines_i;
      sync2_r <= sync1_r;
    end
  end

  // ****************************************************************
  // Cycle sequencer
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= PFCS_CY_IDLE;
      cnt_r <= 4'h0;
    end else begin
      unique case (state_r)
        PFCS_CY_IDLE: begin
          if (cyc.req) begin
            state_r <= cyc.is_write ? PFCS_CY_SETUP : PFCS_CY_RWAIT;
            cnt_r <= cyc.is_write ? 4'h0 : RD_CYC - 4'h1;
          end
        end
        PFCS_CY_SETUP: begin
          state_r <= PFCS_CY_STROBE;
          cnt_r <= WP_CYC - 4'h1;
        end
        PFCS_CY_STROBE: begin
          if (cnt_r == 4'h0) begin
            state_r <= PFCS_CY_HOLD;
            cnt_r <= HOLD_CYC - 4'h1;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        PFCS_CY_HOLD, PFCS_CY_RWAIT: begin
          if (cnt_r == 4'h0) begin
            state_r <= PFCS_CY_IDLE;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        default: state_r <= PFCS_CY_IDLE;
      endcase
    end
  end

  // Address and write data latched at request, stable for the whole cycle
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      address_lines_o <= 16'h0000;
      data_lines_o <= 16'h0000;
    end else if (state_r == PFCS_CY_IDLE && cyc.req) begin
      address_lines_o <= cyc.addr;
      data_lines_o <= cyc.wdata;
    end
  end

  // Strobes are decoded from state; OE never falls during a write
  always_comb begin
    ce_n_o = !(state_r inside {PFCS_CY_SETUP, PFCS_CY_STROBE, PFCS_CY_RWAIT});
    we_n_o = (state_r != PFCS_CY_STROBE);
    oe_n_o = (state_r != PFCS_CY_RWAIT); // RQ9
    data_lines_oe_o = state_r inside {PFCS_CY_SETUP, PFCS_CY_STROBE, PFCS_CY_HOLD};
    cyc.ack = (state_r inside {PFCS_CY_HOLD, PFCS_CY_RWAIT}) && (cnt_r == 4'h0);
    // Taken at ack; a register here would hand over the previous read
    cyc.rdata = sync2_r;
  end
endmodule
`default_nettype wire

// file: core/pfcs_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "pfcs_params.svh"
module pfcs_host #(
  parameter int ERASE_TIMEOUT_CYC = `PFCS_EC_MAX_CYC, // Poll limit in clocks
  parameter bit USE_ALT_UNLOCK2 = 1'b0                // Use 2AA for second unlock
) (
  input wire logic core_clk_i,             // System clock
  input wire logic reset_n_i,              // Async reset, active low
  input wire logic cmd_valid_i,            // Command request
  output logic cmd_ready_o,                // Ready for a command
  input wire pfcs_pkg::pfcs_op_t cmd_op_i, // Operation
  input wire logic [15:0] cmd_addr_i,      // Target or poll address
  input wire logic [15:0] cmd_data_i,      // Write data
  input wire logic boot_locked_i,          // Boot sector lockout applied
  output logic done_o,                     // Command finished, one pulse
  output logic err_o,                      // Refused or timed out, one pulse
  output logic [15:0] rdata_o,             // Last read data
  output logic id_mode_o,                  // Set by ID entry command, cleared by ID exit or reset
  output logic [15:0] address_lines_o,     // Flash address pins
  output logic [15:0] data_lines_o,        // Flash data out
  output logic data_lines_oe_o,            // Data drive enable, high drives
  input wire logic [15:0] data_lines_i,    // Flash data in
  output logic ce_n_o,                     // Chip enable, active low
  output logic oe_n_o,                     // Output enable, active low
  output logic we_n_o                      // Write enable, active low
);
  import pfcs_pkg::*;

  if (ERASE_TIMEOUT_CYC < 1) begin : g_chk
    $error("ERASE_TIMEOUT_CYC must be at least one");
  end

  localparam logic [3:0] OEHP_CYC = 4'(`PFCS_OEHP_CYC);
  localparam logic [31:0] TIMEOUT = 32'(ERASE_TIMEOUT_CYC);
  localparam logic [11:0] UNLOCK2 =
    USE_ALT_UNLOCK2 ? `PFCS_ADDR_UNLOCK2_ALT : `PFCS_ADDR_UNLOCK2; // RQ14

  // ****************************************************************
  // Sequence tables
  // ****************************************************************
  function automatic logic [`PFCS_STEP_W-1:0] seq_len(input pfcs_op_t op);
    unique case (op)
      PFCS_OP_ID_ENTER, PFCS_OP_ID_EXIT3: seq_len = 3'h3;
      PFCS_OP_CHIP_ERASE, PFCS_OP_MAIN_ERASE: seq_len = 3'h6;
      PFCS_OP_WRITE, PFCS_OP_ID_EXIT1: seq_len = 3'h1;
      PFCS_OP_READ, PFCS_OP_POLL: seq_len = 3'h0;
    endcase
  endfunction

  // Command cycles carry the code in the low byte and zero in the upper one
  function automatic logic [15:0] cmd_word(input logic [11:0] a, input logic [7:0] d,
                                           input bit want_addr);
    cmd_word = want_addr ? {4'h0, a} : {8'h00, d}; // RQ7
  endfunction

  function automatic pfcs_step_t seq_step(input pfcs_op_t op,
                                          input logic [`PFCS_STEP_W-1:0] idx,
                                          input logic [15:0] ua,
                                          input logic [15:0] ud);
    logic [11:0] a;
    logic [7:0] d;
    a = `PFCS_ADDR_UNLOCK1;
    d = `PFCS_DATA_UNLOCK1;
    unique case (idx)
      3'h1, 3'h4: begin
        a = UNLOCK2;
        d = `PFCS_DATA_UNLOCK2;
      end
      3'h2: d = (op == PFCS_OP_ID_ENTER) ? `PFCS_CODE_ID_ENTER : // RQ1
                (op == PFCS_OP_ID_EXIT3) ? `PFCS_CODE_ID_EXIT : // RQ3
                `PFCS_CODE_ERASE_SETUP;
      3'h5: d = (op == PFCS_OP_CHIP_ERASE) ? `PFCS_CODE_CHIP_ERASE :
                `PFCS_CODE_MAIN_ERASE; // RQ8
      default: d = `PFCS_DATA_UNLOCK1;
    endcase
    seq_step.addr = cmd_word(a, d, 1'b1);
    seq_step.data = cmd_word(a, d, 1'b0);
    if (op == PFCS_OP_WRITE) begin
      seq_step.addr = ua;
      seq_step.data = ud;
    end else if (op == PFCS_OP_ID_EXIT1) begin
      seq_step.addr = ua;
      seq_step.data = {8'h00, `PFCS_CODE_ID_EXIT}; // RQ2
    end
  endfunction

  pfcs_cyc_if cyc_bus ();

  pfcs_cycle u_cycle (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .cyc(cyc_bus.engine),
    .address_lines_o(address_lines_o),
    .data_lines_o(data_lines_o),
    .data_lines_oe_o(data_lines_oe_o),
    .data_lines_i(data_lines_i),
    .ce_n_o(ce_n_o),
    .oe_n_o(oe_n_o),
    .we_n_o(we_n_o)
  );

  pfcs_main_state_t state_r;
  pfcs_op_t op_r;
  logic [15:0] addr_r;
  logic [15:0] data_r;
  logic [`PFCS_STEP_W-1:0] step_r;
  logic issued_r;
  logic first_r;
  logic tog_r;
  logic [3:0] gap_r;
  logic [31:0] tmo_r;
  logic refuse;
  logic poll_stable;
  pfcs_step_t cur_step;

  // Chip erase would reach the locked boot sector, so it is never sent
  assign refuse = cmd_op_i == PFCS_OP_CHIP_ERASE && boot_locked_i; // RQ13
  assign cur_step = seq_step(op_r, step_r, addr_r, data_r);
  // Only a change matters; the starting level carries no meaning
  assign poll_stable = !first_r &&
    (cyc_bus.rdata[`PFCS_TOGGLE_BIT] == tog_r); // RQ11
  assign cmd_ready_o = (state_r == PFCS_M_IDLE);

  always_comb begin
    cyc_bus.req = 1'b0;
    cyc_bus.is_write = 1'b1;
    cyc_bus.addr = cur_step.addr;
    cyc_bus.wdata = cur_step.data;
    if (state_r == PFCS_M_SEQ && !issued_r) begin
      cyc_bus.req = 1'b1;
    end else if ((state_r == PFCS_M_POLL || state_r == PFCS_M_READ) && !issued_r) begin
      cyc_bus.req = 1'b1;
      cyc_bus.is_write = 1'b0;
      cyc_bus.addr = addr_r; // RQ12
    end
  end

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= PFCS_M_IDLE;
      op_r <= PFCS_OP_READ;
      addr_r <= 16'h0000;
      data_r <= 16'h0000;
      step_r <= '0;
      issued_r <= 1'b0;
      first_r <= 1'b1;
      gap_r <= 4'h0;
    end else begin
      if (cyc_bus.req) begin
        issued_r <= 1'b1;
      end
      unique case (state_r)
        PFCS_M_IDLE: begin
          issued_r <= 1'b0;
          step_r <= '0;
          first_r <= 1'b1;
          if (cmd_valid_i && !refuse) begin
            op_r <= cmd_op_i;
            addr_r <= cmd_addr_i;
            data_r <= cmd_data_i;
            state_r <= (cmd_op_i == PFCS_OP_POLL) ? PFCS_M_POLL :
                       (cmd_op_i == PFCS_OP_READ) ? PFCS_M_READ : PFCS_M_SEQ;
          end
        end
        PFCS_M_SEQ: begin
          if (cyc_bus.ack) begin
            issued_r <= 1'b0;
            step_r <= step_r + 3'h1;
            if (step_r == seq_len(op_r) - 3'h1) begin
              state_r <= (op_r inside {PFCS_OP_CHIP_ERASE, PFCS_OP_MAIN_ERASE}) ?
                         PFCS_M_POLL : PFCS_M_IDLE;
            end
          end
        end
        PFCS_M_POLL: begin
          if (cyc_bus.ack) begin
            issued_r <= 1'b0;
            first_r <= 1'b0;
            if (poll_stable || tmo_r >= TIMEOUT) begin
              state_r <= PFCS_M_IDLE;
            end else begin
              // OE must stay high long enough for the bit to advance
              state_r <= PFCS_M_GAP; // RQ10
              gap_r <= OEHP_CYC - 4'h1;
            end
          end
        end
        PFCS_M_GAP: begin
          if (gap_r == 4'h0) begin
            state_r <= PFCS_M_POLL;
          end else begin
            gap_r <= gap_r - 4'h1;
          end
        end
        PFCS_M_READ: begin
          if (cyc_bus.ack) begin
            state_r <= PFCS_M_IDLE;
          end
        end
        default: state_r <= PFCS_M_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tog_r <= 1'b0;
    end else if (state_r == PFCS_M_POLL && cyc_bus.ack) begin
      tog_r <= cyc_bus.rdata[`PFCS_TOGGLE_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tmo_r <= 32'h0;
    end else if (state_r == PFCS_M_IDLE) begin
      tmo_r <= 32'h0;
    end else if (tmo_r < TIMEOUT) begin
      tmo_r <= tmo_r + 32'h1;
    end
  end

  // ****************************************************************
  // Results
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_o <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= 16'h0000;
    end else begin
      done_o <= 1'b0;
      err_o <= 1'b0;
      if (state_r == PFCS_M_IDLE && cmd_valid_i && refuse) begin
        err_o <= 1'b1;
        done_o <= 1'b1;
      end
      if (state_r == PFCS_M_SEQ && cyc_bus.ack && step_r == seq_len(op_r) - 3'h1 &&
          !(op_r inside {PFCS_OP_CHIP_ERASE, PFCS_OP_MAIN_ERASE})) begin
        done_o <= 1'b1;
      end
      if (state_r == PFCS_M_POLL && cyc_bus.ack && (poll_stable || tmo_r >= TIMEOUT)) begin
        done_o <= 1'b1;
        err_o <= !poll_stable;
        // Status reads surface as data only once the toggling stops or the poll times out
        rdata_o <= cyc_bus.rdata; // RQ15
      end
      if (state_r == PFCS_M_READ && cyc_bus.ack) begin
        done_o <= 1'b1;
        // In ID mode address 0 gives the maker code, address 1 the part code
        rdata_o <= cyc_bus.rdata; // RQ4
      end
    end
  end

  // Reset stands for power-up: the device is back in array read
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      id_mode_o <= 1'b0; // RQ5
    end else if (state_r == PFCS_M_SEQ && cyc_bus.ack && step_r == seq_len(op_r) - 3'h1) begin
      if (op_r == PFCS_OP_ID_ENTER) begin
        id_mode_o <= 1'b1; // RQ1
      end else if (op_r inside {PFCS_OP_ID_EXIT1, PFCS_OP_ID_EXIT3}) begin
        id_mode_o <= 1'b0; // RQ6
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/pfcs_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************
// Flash device model
// ************************************************
module pfcs_flash_model #(
  parameter int BUSY_READS = 5,               // Status reads per erase
  parameter logic [15:0] MAKER_ID = 16'h00C5, // Arbitrary value
  parameter logic [15:0] PART_ID = 16'h0A3E   // Arbitrary value
) (
  input wire logic por_n_i,       // Power good
  input wire logic stuck_i,       // Erase never ends
  input wire logic [15:0] addr_i, // Address pins
  input wire logic [15:0] hdat_i, // Host data drive
  input wire logic hdat_oe_i,     // Host drives data
  input wire logic ce_n_i,        // Chip enable
  input wire logic oe_n_i,        // Output enable
  input wire logic we_n_i,        // Write enable
  output logic [15:0] data_o      // Resolved data wire
);
  logic [2:0] st;
  logic id_m;
  logic tog;
  logic [1:0] er;
  int busy;
  logic [15:0] rv;
  logic [15:0] last;
  wire wr = !we_n_i && !ce_n_i && oe_n_i;
  wire rd = !ce_n_i && !oe_n_i && we_n_i;
  wire [7:0] c = hdat_i[7:0];
  wire a1 = addr_i[10:0] == 11'h555;
  wire a2 = addr_i[10:0] == 11'h2AA;
  initial begin
    st = 3'h0;
    id_m = 1'b0;
    tog = 1'b0;
    er = 2'h0;
    busy = 0;
    last = 16'h0000;
  end
  always_comb begin
    if (busy != 0) rv = {9'h000, tog, 6'h00};
    else if (id_m && addr_i[15:1] == 15'h0000) rv = addr_i[0] ? PART_ID : MAKER_ID;
    else if (er == 2'h2 || (er == 2'h1 && addr_i > 16'h1FFF)) rv = 16'hFFFF;
    else rv = addr_i ^ 16'hC3C3;
  end
  // Released bus shows the inverse of the last word so a stale match cannot pass
  always @(negedge rd) last <= rv;
  assign data_o = hdat_oe_i ? hdat_i : (rd ? rv : ~last);
  always @(negedge wr or posedge rd or negedge por_n_i) begin
    if (!por_n_i) begin
      st <= 3'h0;
      id_m <= 1'b0;
    end else if (rd) begin
      if (busy != 0) begin
        tog <= !tog;
        if (!stuck_i) busy <= busy - 1;
      end
    end else begin
      st <= 3'h0;
      case (st)
        3'h0: if (a1 && c == 8'hAA) st <= 3'h1;
        3'h1: if (a2 && c == 8'h55) st <= 3'h2;
        3'h2: begin
          if (a1 && c == 8'h90) id_m <= 1'b1;
          if (a1 && c == 8'h80) st <= 3'h3;
        end
        3'h3: if (a1 && c == 8'hAA) st <= 3'h4;
        3'h4: if (a2 && c == 8'h55) st <= 3'h5;
        3'h5: if (a1 && (c == 8'h10 || c == 8'h30)) begin
          er <= (c == 8'h10) ? 2'h2 : 2'h1;
          busy <= BUSY_READS;
        end
        default: ;
      endcase
      if (c == 8'hF0) id_m <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: verification/pfcs_host_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************
// Port checker
// ************************************************
module pfcs_host_assertions import pfcs_pkg::*; #(
  parameter int ERASE_TIMEOUT_CYC = 200 // Poll limit in clocks
) (
  input wire logic core_clk_i,                // Clock
  input wire logic reset_n_i,                 // Reset, active low
  input wire logic cmd_valid_i,               // Command request
  input wire logic cmd_ready_o,               // Ready
  input wire pfcs_pkg::pfcs_op_t cmd_op_i,    // Operation
  input wire logic boot_locked_i,             // Lockout applied
  input wire logic done_o,                    // Finished
  input wire logic err_o,                     // Refused or timed out
  input wire logic id_mode_o,                 // ID mode view
  input wire logic [15:0] address_lines_o,    // Address pins
  input wire logic [15:0] data_lines_o,       // Data out
  input wire logic data_lines_oe_o,           // Data drive
  input wire logic ce_n_o,                    // Chip enable
  input wire logic oe_n_o,                    // Output enable
  input wire logic we_n_o                     // Write enable
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire take = cmd_valid_i && cmd_ready_o;
  wire refuse = take && cmd_op_i == PFCS_OP_CHIP_ERASE && boot_locked_i;
  wire erase = cmd_op_i == PFCS_OP_CHIP_ERASE || cmd_op_i == PFCS_OP_MAIN_ERASE;
  logic poll_r;
  int cnt_r;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) poll_r <= 1'b0;
    else if (take && (erase || cmd_op_i == PFCS_OP_POLL) && !refuse) poll_r <= 1'b1;
    else if (done_o) poll_r <= 1'b0;
  end
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) cnt_r <= 0;
    else cnt_r <= poll_r ? cnt_r + 1 : 0;
  end
  property p_rst; $rose(reset_n_i) |-> cmd_ready_o && ce_n_o && !id_mode_o; endproperty
  a_rst: assert property (p_rst) else $error("pins not idle after reset");
  property p_wr; !we_n_o |-> oe_n_o && !ce_n_o && data_lines_oe_o; endproperty
  a_wr: assert property (p_wr) else $error("write strobe with output enable");
  property p_rd; !oe_n_o |-> !ce_n_o && we_n_o && !data_lines_oe_o; endproperty
  a_rd: assert property (p_rd) else $error("read overlaps a drive");
  property p_addr; !oe_n_o && !$past(oe_n_o) |-> $stable(address_lines_o); endproperty
  a_addr: assert property (p_addr) else $error("address moved in a read");
  property p_gap; $rose(oe_n_o) && poll_r |-> oe_n_o [*3]; endproperty
  a_gap: assert property (p_gap) else $error("poll gap too short");
  property p_upper; $fell(we_n_o) && poll_r |-> data_lines_o[15:8] == 8'h00
    && address_lines_o[15:12] == 4'h0; endproperty
  a_upper: assert property (p_upper) else $error("command upper bits set");
  property p_tmo; poll_r |-> cnt_r <= ERASE_TIMEOUT_CYC + 16; endproperty
  a_tmo: assert property (p_tmo) else $error("poll ran past its limit");
  property p_ent; take && cmd_op_i == PFCS_OP_ID_ENTER |-> ##[4:30] done_o ##[0:1] id_mode_o;
  endproperty
  a_ent: assert property (p_ent) else $error("id entry not shown");
  property p_ex1; take && cmd_op_i == PFCS_OP_ID_EXIT1 |-> ##[2:15] done_o ##[0:1] !id_mode_o;
  endproperty
  a_ex1: assert property (p_ex1) else $error("short id exit not shown");
  property p_ex3; take && cmd_op_i == PFCS_OP_ID_EXIT3 |-> ##[4:30] done_o ##[0:1] !id_mode_o;
  endproperty
  a_ex3: assert property (p_ex3) else $error("long id exit not shown");
  property p_ref; refuse |=> done_o && err_o; endproperty
  a_ref: assert property (p_ref) else $error("locked erase not refused");
  property p_quiet; refuse |-> ce_n_o [*3]; endproperty
  a_quiet: assert property (p_quiet) else $error("pins moved on refusal");
endmodule
bind pfcs_host pfcs_host_assertions #(.ERASE_TIMEOUT_CYC(ERASE_TIMEOUT_CYC)) u_chk (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i),
  .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i), .boot_locked_i(boot_locked_i),
  .done_o(done_o), .err_o(err_o), .id_mode_o(id_mode_o), .address_lines_o(address_lines_o),
  .data_lines_o(data_lines_o), .data_lines_oe_o(data_lines_oe_o), .ce_n_o(ce_n_o),
  .oe_n_o(oe_n_o), .we_n_o(we_n_o)
);
`default_nettype wire

// file: verification/test_parallel_flash_command_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************
// Bench
// ************************************************
module test_parallel_flash_command_sequencer;
  import pfcs_pkg::*;
  localparam int TMO = 200;
  localparam logic [15:0] MAKER = 16'h00C5; // Arbitrary value
  localparam logic [15:0] PART = 16'h0A3E;  // Arbitrary value
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  pfcs_op_t cmd_op_i = PFCS_OP_READ;
  logic [15:0] cmd_addr_i = 16'h0000;
  logic [15:0] cmd_data_i = 16'h0000;
  logic boot_locked_i = 1'b0;
  logic stuck = 1'b0;
  logic cmd_ready_o, done_o, err_o, id_mode_o, data_lines_oe_o, ce_n_o, oe_n_o, we_n_o;
  logic [15:0] rdata_o, address_lines_o, data_lines_o, data_lines_i, rd_w;
  logic er_b;
  int error_cnt = 0;
  int n_compared = 0;
  always #25 core_clk_i = ~core_clk_i;
  pfcs_host #(.ERASE_TIMEOUT_CYC(TMO)) u_dut (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
    .cmd_data_i(cmd_data_i), .boot_locked_i(boot_locked_i), .done_o(done_o), .err_o(err_o),
    .rdata_o(rdata_o), .id_mode_o(id_mode_o), .address_lines_o(address_lines_o),
    .data_lines_o(data_lines_o), .data_lines_oe_o(data_lines_oe_o),
    .data_lines_i(data_lines_i), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o)
  );
  pfcs_flash_model #(.BUSY_READS(5), .MAKER_ID(MAKER), .PART_ID(PART)) u_flash (
    .por_n_i(reset_n_i), .stuck_i(stuck), .addr_i(address_lines_o), .hdat_i(data_lines_o),
    .hdat_oe_i(data_lines_oe_o), .ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o),
    .data_o(data_lines_i)
  );
  function automatic logic [15:0] pat(input logic [15:0] a);
    return a ^ 16'hC3C3;
  endfunction
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rst();
    reset_n_i = 1'b0;
    repeat (20) @(posedge core_clk_i);
    #1;
    reset_n_i = 1'b1;
  endtask
  // Valid is held for exactly the taking edge; done stands one cycle
  task automatic run(input pfcs_op_t op, input logic [15:0] a, input logic [15:0] d);
    int n;
    n = 0;
    cmd_op_i = op;
    cmd_addr_i = a;
    cmd_data_i = d;
    cmd_valid_i = 1'b1;
    @(posedge core_clk_i);
    #1;
    cmd_valid_i = 1'b0;
    while (done_o !== 1'b1 && n < 400) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    if (n >= 400) error_cnt++;
    rd_w = rdata_o;
    er_b = err_o;
    @(posedge core_clk_i);
    #1;
  endtask
  task automatic rdx(input logic [15:0] a, input logic [15:0] exp);
    run(PFCS_OP_READ, a, 16'h0000);
    check(rd_w, exp);
  endtask
  task automatic t_power();
    check({15'h0000, id_mode_o}, 16'h0000);
    run(PFCS_OP_ID_ENTER, 16'h0000, 16'h0000);
    rdx(16'h0000, MAKER);
    rst();
    check({15'h0000, id_mode_o}, 16'h0000);
    rdx(16'h0000, pat(16'h0000));
    $display("test power done");
  endtask
  task automatic t_id();
    run(PFCS_OP_ID_ENTER, 16'h0000, 16'h0000);
    check({15'h0000, id_mode_o}, 16'h0001);
    rdx(16'h0001, PART);
    run(PFCS_OP_ID_EXIT1, 16'h7ABC, 16'h0000);
    check({15'h0000, id_mode_o}, 16'h0000);
    rdx(16'h0001, pat(16'h0001));
    run(PFCS_OP_ID_ENTER, 16'h0000, 16'h0000);
    rdx(16'h0000, MAKER);
    run(PFCS_OP_ID_EXIT3, 16'h0000, 16'h0000);
    check({15'h0000, id_mode_o}, 16'h0000);
    rdx(16'h0000, pat(16'h0000));
    $display("test id done");
  endtask
  task automatic t_manual();
    run(PFCS_OP_WRITE, 16'hF555, 16'h12AA);
    run(PFCS_OP_WRITE, 16'h02AA, 16'h3455);
    run(PFCS_OP_WRITE, 16'h8555, 16'hFF90);
    rdx(16'h0000, MAKER);
    run(PFCS_OP_WRITE, 16'h4321, 16'h00F0);
    rdx(16'h0000, pat(16'h0000));
    $display("test manual done");
  endtask
  task automatic t_erase();
    boot_locked_i = 1'b1;
    run(PFCS_OP_CHIP_ERASE, 16'h0000, 16'h0000);
    check({15'h0000, er_b}, 16'h0001);
    boot_locked_i = 1'b0;
    run(PFCS_OP_MAIN_ERASE, 16'h4000, 16'h0000);
    check({15'h0000, er_b}, 16'h0000);
    rdx(16'h0100, pat(16'h0100));
    rdx(16'h8000, 16'hFFFF);
    stuck = 1'b1;
    run(PFCS_OP_CHIP_ERASE, 16'h0123, 16'h0000);
    check({15'h0000, er_b}, 16'h0001);
    run(PFCS_OP_READ, 16'h0123, 16'h0000);
    check(rd_w & 16'hFFBF, 16'h0000);
    stuck = 1'b0;
    run(PFCS_OP_POLL, 16'h0123, 16'h0000);
    check({15'h0000, er_b}, 16'h0000);
    rdx(16'h0100, 16'hFFFF);
    $display("test erase done");
  endtask
  initial begin
    #(50 * 20000);
    error_cnt++;
    summarize();
  end
  initial begin
    rst();
    t_power();
    t_id();
    t_manual();
    t_erase();
    summarize();
  end
endmodule
`default_nettype wire
